// [logic/motion_event_pkg.sv]
// shared constants and carrier types for the inertial event block
package motion_event_pkg;

   // register offsets on the host port
   localparam logic [7:0] ADDR_ONE_THRESHOLD = 8'h32;
   localparam logic [7:0] ADDR_ONE_DURATION = 8'h33;
   localparam logic [7:0] ADDR_TWO_CONFIG = 8'h34;
   localparam logic [7:0] ADDR_TWO_SOURCE = 8'h35;
   localparam logic [7:0] ADDR_TWO_THRESHOLD = 8'h36;
   localparam logic [7:0] ADDR_TWO_DURATION = 8'h37;
   localparam logic [7:0] ADDR_TAP_CONFIG = 8'h38;

   // field widths and reset values
   localparam int REG_W = 8;
   localparam int THR_W = 7;
   localparam int DUR_W = 7;
   localparam int FLAG_W = 6;
   localparam int SAMPLE_W = 16;
   localparam logic [THR_W-1:0] THRESHOLD_RESET = 7'h00;
   localparam logic [DUR_W-1:0] DURATION_RESET = 7'h00;
   localparam logic [REG_W-1:0] UNMAPPED_READ = 8'h00;

   // magnitude bits below this position fall under one threshold step
   localparam int MAG_LSB = 8;

   // boot load time of the configuration register
   localparam int CLK_PERIOD_NS = 10;
   localparam int BOOT_TIME_NS = 50;
   localparam int BOOT_CYCLES =
      (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOOT_CNT_W = 4;

   // combine modes: {and_or_select, orientation_detect_enable}
   typedef enum logic [1:0] {
      MODE_OR = 2'b00,
      MODE_MOVE = 2'b01,
      MODE_AND = 2'b10,
      MODE_POS = 2'b11
   } combine_mode_t;

   // one-hot phases of the block
   typedef enum logic [1:0] {
      PH_BOOT = 2'b01,
      PH_RUN = 2'b10
   } phase_t;

   // per-axis flags in source-register order
   typedef struct packed {
      logic z_above;
      logic z_below;
      logic y_above;
      logic y_below;
      logic x_above;
      logic x_below;
   } axis_flags_t;

   typedef struct packed {
      logic and_or_select;
      logic orientation_detect_enable;
      axis_flags_t enables;
   } event_config_t;

   typedef struct packed {
      logic z_double_tap_enable;
      logic z_single_tap_enable;
      logic y_double_tap_enable;
      logic y_single_tap_enable;
      logic x_double_tap_enable;
      logic x_single_tap_enable;
   } tap_config_t;

   // host port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // one sample per output data rate period
   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] x;
      logic [SAMPLE_W-1:0] y;
      logic [SAMPLE_W-1:0] z;
   } sample_t;

   // whole state of the top module
   typedef struct packed {
      phase_t phase;
      logic [BOOT_CNT_W-1:0] boot_cnt;
      logic [THR_W-1:0] one_threshold;
      logic [DUR_W-1:0] one_duration;
      event_config_t two_config;
      logic [THR_W-1:0] two_threshold;
      logic [DUR_W-1:0] two_duration;
      tap_config_t tap;
      axis_flags_t two_flags;
      logic two_active;
      logic [DUR_W-1:0] persist_cnt;
      logic qual_prev;
      logic [REG_W-1:0] rdata;
   } block_state_t;

endpackage

// [logic/axis_compare.sv]
// one axis compared against a threshold, both signed and by magnitude
module axis_compare
   import motion_event_pkg::*;
#(
   parameter int W = SAMPLE_W
) (
   input wire logic [W-1:0] sample_i,
   input wire logic [THR_W-1:0] threshold_i,
   output logic pos_above_o,
   output logic neg_above_o,
   output logic mag_above_o,
   output logic mag_below_o
);

   // the scaled magnitude must hold every threshold step
   if (W - MAG_LSB < THR_W + 1) begin : g_bad_width
      $error("axis_compare: sample too narrow for threshold");
   end

   logic [W-1:0] mag;
   logic [W-MAG_LSB-1:0] scaled;
   logic [W-MAG_LSB-1:0] thr_ext;

   // two's complement magnitude, full-scale counts so the step scales
   assign mag = sample_i[W-1] ? W'(~sample_i + 1'b1) : sample_i;
   assign scaled = mag[W-1:MAG_LSB];
   assign thr_ext = (W - MAG_LSB)'(threshold_i);

   // magnitude against threshold, then split by sign for orientation
   assign mag_above_o = scaled > thr_ext;
   assign mag_below_o = scaled < thr_ext;
   assign pos_above_o = mag_above_o && !sample_i[W-1];
   assign neg_above_o = mag_above_o && sample_i[W-1];

endmodule

// [logic/motion_event_top.sv]
// inertial event generators with their host-port registers
//
// What this block does
// - generator one threshold: seven bits, reset zero, step follows full scale
// - generator two threshold: seven bits, reset zero, step follows full scale
// - generator one duration: seven-bit sample count, reset zero
// - generator two fires only after condition lasts duration samples
// - mode pair: 00 or, 01 movement, 10 and, 11 position
// - movement mode: event on unknown-to-known zone change, one sample long
// - position mode: event stays while orientation is in a known zone
// - per-axis above enables, reset zero, request on exceeding threshold
// - per-axis below enables, reset zero, request below threshold in or/and modes, on negative excess in movement/position modes
// - configuration loaded at boot; host writes only after boot
// - source register read-only; active bit set once events occur
// - source holds per-axis above and below flags, reset zero
// - source read clears active and pin, lets latched flags refresh
// - tap register holds per-axis double-tap enables, reset zero
// - tap register holds per-axis single-tap enables, reset zero
module motion_event_top
   import motion_event_pkg::*;
#(
   parameter logic [REG_W-1:0] BOOT_CONFIG = 8'h00
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire reg_req_t reg_req_i,
   input wire sample_t sample_i,
   input wire logic latch_enable_i,
   input wire logic reboot_i,
   output logic [REG_W-1:0] reg_rdata_o,
   output logic event_two_o,
   output logic boot_busy_o,
   output logic [THR_W-1:0] one_threshold_o,
   output logic [DUR_W-1:0] one_duration_o,
   output tap_config_t tap_enable_o
);

   // the boot counter must reach the boot length
   if (BOOT_CYCLES < 1 || BOOT_CYCLES >= (1 << BOOT_CNT_W)) begin : g_bad
      $error("motion_event_top: boot length does not fit its counter");
   end

   block_state_t s_r;
   block_state_t s_nxt;

   logic [2:0] pos_above;
   logic [2:0] neg_above;
   logic [2:0] mag_above;
   logic [2:0] mag_below;
   logic [SAMPLE_W-1:0] axis_sample [3];

   // axis order 0 = x, 1 = y, 2 = z
   assign axis_sample[0] = sample_i.x;
   assign axis_sample[1] = sample_i.y;
   assign axis_sample[2] = sample_i.z;

   // compare each axis against the generator two threshold
   for (genvar g = 0; g < 3; g++) begin : g_axis
      axis_compare #(
         .W(SAMPLE_W)
      ) u_cmp (
         .sample_i(axis_sample[g]),
         .threshold_i(s_r.two_threshold),
         .pos_above_o(pos_above[g]),
         .neg_above_o(neg_above[g]),
         .mag_above_o(mag_above[g]),
         .mag_below_o(mag_below[g])
      );
   end

   combine_mode_t mode;
   axis_flags_t hits;
   axis_flags_t masked;
   logic known;
   logic base_cond;
   logic qual;
   logic fire;
   logic src_read;

   // per-axis hits: signed direction in orientation modes, else magnitude
   always_comb begin
      if (s_r.two_config.orientation_detect_enable) begin
         hits = '{z_above: pos_above[2], z_below: neg_above[2],
                  y_above: pos_above[1], y_below: neg_above[1],
                  x_above: pos_above[0], x_below: neg_above[0]};
      end else begin
         hits = '{z_above: mag_above[2], z_below: mag_below[2],
                  y_above: mag_above[1], y_below: mag_below[1],
                  x_above: mag_above[0], x_below: mag_below[0]};
      end
   end

   // enabled requests and the combined condition
   always_comb begin
      mode = combine_mode_t'({s_r.two_config.and_or_select,
                              s_r.two_config.orientation_detect_enable});
      masked = hits & s_r.two_config.enables;
      known = $onehot(hits) && (masked != '0);
      unique case (mode)
         MODE_OR: base_cond = masked != '0;
         MODE_AND: base_cond = (s_r.two_config.enables != '0)
                               && (masked == s_r.two_config.enables);
         MODE_MOVE: base_cond = known;
         MODE_POS: base_cond = known;
      endcase
      // persistence over duration sample periods
      qual = base_cond && (s_r.persist_cnt >= s_r.two_duration);
      if (mode == MODE_MOVE) begin
         fire = qual && !s_r.qual_prev;
      end else begin
         fire = qual;
      end
   end

   assign src_read = reg_req_i.rd && (reg_req_i.addr == ADDR_TWO_SOURCE);

   // next state: boot, register access, sample evaluation
   always_comb begin
      s_nxt = s_r;
      // boot loads configuration, then run
      unique case (s_r.phase)
         PH_BOOT: begin
            if (s_r.boot_cnt == BOOT_CNT_W'(BOOT_CYCLES - 1)) begin
               s_nxt.phase = PH_RUN;
               s_nxt.two_config = event_config_t'(BOOT_CONFIG);
            end else begin
               s_nxt.boot_cnt = s_r.boot_cnt + 1'b1;
            end
         end
         PH_RUN: begin
            if (reboot_i) begin
               s_nxt.phase = PH_BOOT;
               s_nxt.boot_cnt = '0;
            end
         end
      endcase

      // host writes; upper bits are not stored
      if (reg_req_i.wr) begin
         unique case (reg_req_i.addr)
            ADDR_ONE_THRESHOLD:
               s_nxt.one_threshold = reg_req_i.wdata[THR_W-1:0];
            ADDR_ONE_DURATION:
               s_nxt.one_duration = reg_req_i.wdata[DUR_W-1:0];
            ADDR_TWO_CONFIG: begin
               if (s_r.phase == PH_RUN) begin
                  s_nxt.two_config = event_config_t'(reg_req_i.wdata);
               end
            end
            ADDR_TWO_THRESHOLD:
               s_nxt.two_threshold = reg_req_i.wdata[THR_W-1:0];
            ADDR_TWO_DURATION:
               s_nxt.two_duration = reg_req_i.wdata[DUR_W-1:0];
            ADDR_TAP_CONFIG:
               s_nxt.tap = tap_config_t'(reg_req_i.wdata[FLAG_W-1:0]);
            default: ;
         endcase
      end

      // host reads; unmapped addresses answer a fixed value, unused top bits read zero
      if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            ADDR_ONE_THRESHOLD: s_nxt.rdata = {1'b0, s_r.one_threshold};
            ADDR_ONE_DURATION: s_nxt.rdata = {1'b0, s_r.one_duration};
            ADDR_TWO_CONFIG: s_nxt.rdata = s_r.two_config;
            ADDR_TWO_SOURCE:
               s_nxt.rdata = {1'b0, s_r.two_active, s_r.two_flags};
            ADDR_TWO_THRESHOLD: s_nxt.rdata = {1'b0, s_r.two_threshold};
            ADDR_TWO_DURATION: s_nxt.rdata = {1'b0, s_r.two_duration};
            ADDR_TAP_CONFIG: s_nxt.rdata = {2'b00, s_r.tap};
            default: s_nxt.rdata = UNMAPPED_READ;
         endcase
      end

      // a source read drops the active bit and the pin
      if (src_read) begin
         s_nxt.two_active = 1'b0;
      end

      // one evaluation per sample; a new event wins over the read clear
      if (sample_i.valid && s_r.phase == PH_RUN) begin
         s_nxt.qual_prev = qual;
         if (base_cond) begin
            if (s_r.persist_cnt < s_r.two_duration) begin
               s_nxt.persist_cnt = s_r.persist_cnt + 1'b1;
            end
         end else begin
            s_nxt.persist_cnt = '0;
         end
         if (latch_enable_i) begin
            // latched: flags freeze until the source is read
            if (fire && (!s_r.two_active || src_read)) begin
               s_nxt.two_active = 1'b1;
               s_nxt.two_flags = masked;
            end
         end else begin
            s_nxt.two_active = fire;
            s_nxt.two_flags = fire ? masked : '0;
         end
      end
   end

   // single state register
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         s_r.phase <= PH_BOOT;
         s_r.one_threshold <= THRESHOLD_RESET;
         s_r.two_threshold <= THRESHOLD_RESET;
         s_r.one_duration <= DURATION_RESET;
         s_r.two_duration <= DURATION_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign reg_rdata_o = s_r.rdata;
   assign event_two_o = s_r.two_active;
   assign boot_busy_o = s_r.phase == PH_BOOT ? 1'b1 : 1'b0;
   assign one_threshold_o = s_r.one_threshold;
   assign one_duration_o = s_r.one_duration;
   assign tap_enable_o = s_r.tap;

   // checks of the guarded behaviour
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // a source read with no new event in the same cycle
   sequence src_read_quiet;
      src_read && !(sample_i.valid && fire);
   endsequence

   // a configuration write while the boot load runs
   sequence boot_write;
      boot_busy_o && reg_req_i.wr && reg_req_i.addr == ADDR_TWO_CONFIG;
   endsequence

   // a sample evaluated with the source following each sample
   sequence live_sample;
      sample_i.valid && !boot_busy_o && !latch_enable_i;
   endsequence

   // read drops the pin; the top data bit reads zero
   a_read_clears_pin: assert property (
      src_read_quiet |=> !event_two_o && reg_rdata_o[REG_W-1] == 1'b0)
      else $error("source read did not clear the event pin");

   // configuration ignores host writes until the boot load at boot end
   a_boot_write_blocked: assert property (
      boot_write |=> $stable(s_r.two_config)
         || $past(s_r.boot_cnt) == BOOT_CNT_W'(BOOT_CYCLES - 1))
      else $error("configuration written during boot");

   // samples during boot leave the source alone
   a_boot_ignores_samples: assert property (
      boot_busy_o && sample_i.valid
         |=> $stable(s_r.two_flags) && $stable(s_r.persist_cnt))
      else $error("sample evaluated during boot");

   // thresholds, durations, pin and flags zero and boot running at the first edge after reset
   a_thresholds_reset: assert property (
      $rose(rstn_i) |-> one_threshold_o == '0 && one_duration_o == '0
         && s_r.two_threshold == '0 && s_r.two_duration == '0
         && !event_two_o && s_r.two_flags == '0 && boot_busy_o)
      else $error("thresholds or flags not zero after reset");

   // no event before the condition lasted the duration
   a_fire_needs_time: assert property (
      live_sample ##0 s_r.persist_cnt < s_r.two_duration |=> !event_two_o)
      else $error("event before the duration elapsed");

   // movement: a second qualifying sample in a row raises nothing
   a_move_one_sample: assert property (
      live_sample ##0 mode == MODE_MOVE && s_r.qual_prev |=> !event_two_o)
      else $error("movement event repeated in a known zone");

   // movement: entering a known zone raises the pin
   a_move_fires_entry: assert property (
      live_sample ##0 mode == MODE_MOVE && qual && !s_r.qual_prev
         |=> event_two_o)
      else $error("movement into a known zone missed");

   // position: the pin follows the zone
   a_position_holds: assert property (
      live_sample ##0 mode == MODE_POS && qual ##1 !src_read |-> event_two_o)
      else $error("position event dropped inside a zone");

   // position: no event outside exactly one zone
   a_pos_needs_zone: assert property (
      live_sample ##0 mode == MODE_POS && !$onehot(hits) |=> !event_two_o)
      else $error("position event without a single known zone");

   // and mode: one enabled axis missing blocks the event
   a_and_needs_all: assert property (
      live_sample ##0 mode == MODE_AND
         && masked != s_r.two_config.enables |=> !event_two_o)
      else $error("and mode fired with an enabled axis missing");

   // or mode: any enabled axis raises the pin with its flag
   a_or_mode_flags: assert property (
      live_sample ##0 mode == MODE_OR && s_r.two_duration == '0
         && masked != '0 |=> event_two_o && s_r.two_flags == $past(masked))
      else $error("or mode missed an enabled axis");

   // source read returns the pin level and the flags
   a_source_read_data: assert property (
      src_read |=> reg_rdata_o[REG_W-2] == $past(event_two_o)
         && reg_rdata_o[FLAG_W-1:0] == $past(s_r.two_flags))
      else $error("source read returned wrong contents");

   // host writes leave the source alone
   a_source_read_only: assert property (
      reg_req_i.wr && reg_req_i.addr == ADDR_TWO_SOURCE && !sample_i.valid
         |=> $stable(s_r.two_flags))
      else $error("source register took a host write");

   // generator two threshold and generator one duration registers read a zero top bit
   a_msb_reads_zero: assert property (
      reg_req_i.rd && (reg_req_i.addr == ADDR_TWO_THRESHOLD
         || reg_req_i.addr == ADDR_ONE_DURATION)
         |=> reg_rdata_o[REG_W-1] == 1'b0)
      else $error("top bit of a seven-bit register read set");

   // unused tap bits read zero
   a_tap_top_zero: assert property (
      reg_req_i.rd && reg_req_i.addr == ADDR_TAP_CONFIG
         |=> reg_rdata_o[REG_W-1:FLAG_W] == '0)
      else $error("unused tap bits read set");

   // tap enables keep what was written
   a_tap_write_kept: assert property (
      reg_req_i.wr && reg_req_i.addr == ADDR_TAP_CONFIG
         |=> tap_enable_o == $past(reg_req_i.wdata[FLAG_W-1:0]))
      else $error("tap enables not stored");

   // latched flags hold until the source is read
   a_latched_freeze: assert property (
      latch_enable_i && event_two_o && !src_read ##0 !reboot_i
         |=> $stable(s_r.two_flags) || !latch_enable_i)
      else $error("latched flags changed before a read");

endmodule

// [tb/tb_motion_event_top.sv]
// self-checking bench for the inertial event block through its host port
module tb_motion_event_top;
   timeunit 1ns;
   timeprecision 1ps;
   import motion_event_pkg::*;

   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   reg_req_t reg_req_i = '0;
   sample_t sample_i = '0;
   logic latch_enable_i = 1'b0;
   logic reboot_i = 1'b0;
   logic [REG_W-1:0] reg_rdata_o;
   logic event_two_o;
   logic boot_busy_o;
   logic [THR_W-1:0] one_threshold_o;
   logic [DUR_W-1:0] one_duration_o;
   tap_config_t tap_enable_o;
   int errors = 0;
   int check_count = 0;

   // 100 MHz clock
   always #5 core_clk_i = ~core_clk_i;

   motion_event_top motion_event_top_i (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .reg_req_i(reg_req_i),
      .sample_i(sample_i),
      .latch_enable_i(latch_enable_i),
      .reboot_i(reboot_i),
      .reg_rdata_o(reg_rdata_o),
      .event_two_o(event_two_o),
      .boot_busy_o(boot_busy_o),
      .one_threshold_o(one_threshold_o),
      .one_duration_o(one_duration_o),
      .tap_enable_o(tap_enable_o)
   );

   // byte compare
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t byte got %h want %h", $time, got, exp);
      end
   endtask

   // single flag compare
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t flag got %b want %b", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_req_i <= {1'b0, 1'b1, a, d};
      @(posedge core_clk_i);
      reg_req_i <= '0;
   endtask

   // one-cycle read strobe, data lands at the following edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      reg_req_i <= {1'b1, 1'b0, a, 8'h00};
      @(posedge core_clk_i);
      reg_req_i <= '0;
      #1;
      chk8(reg_rdata_o, exp);
   endtask

   // one sample pulse, pin checked one edge later
   task automatic smp(input logic [15:0] x, input logic [15:0] y,
                      input logic [15:0] z, input logic e);
      @(posedge core_clk_i);
      sample_i <= {1'b1, x, y, z};
      @(posedge core_clk_i);
      sample_i.valid <= 1'b0;
      #1;
      chk1(event_two_o, e);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, checks %0d, errors %0d", name, check_count,
               errors);
   endtask

   task automatic wait_boot();
      for (int i = 0; i < 20 && boot_busy_o !== 1'b0; i++) begin
         @(posedge core_clk_i);
         #1;
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #50000;
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      print_verdict();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk1(boot_busy_o, 1'b1);
      wr(ADDR_TWO_CONFIG, 8'hff);
      wait_boot();
      chk1(boot_busy_o, 1'b0);
      rd(ADDR_TWO_CONFIG, 8'h00);
      rd(ADDR_ONE_THRESHOLD, 8'h00);
      rd(ADDR_ONE_DURATION, 8'h00);
      rd(ADDR_TWO_SOURCE, 8'h00);
      rd(ADDR_TWO_THRESHOLD, 8'h00);
      rd(ADDR_TWO_DURATION, 8'h00);
      rd(ADDR_TAP_CONFIG, 8'h00);
      rd(8'h39, UNMAPPED_READ);
      end_test("reset");

      // top bits dropped, source not writable
      wr(ADDR_ONE_THRESHOLD, 8'hff);
      wr(ADDR_ONE_DURATION, 8'hd5);
      wr(ADDR_TWO_SOURCE, 8'hff);
      rd(ADDR_ONE_THRESHOLD, 8'h7f);
      chk8({1'b0, one_threshold_o}, 8'h7f);
      chk8({1'b0, one_duration_o}, 8'h55);
      rd(ADDR_ONE_DURATION, 8'h55);
      rd(ADDR_TWO_SOURCE, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_TAP_CONFIG, 8'hc0 | (8'h01 << i));
         #1;
         chk8({2'b00, tap_enable_o}, 8'h01 << i);
         rd(ADDR_TAP_CONFIG, 8'h01 << i);
      end
      wr(ADDR_TWO_THRESHOLD, 8'h90);
      rd(ADDR_TWO_THRESHOLD, 8'h10);
      wr(ADDR_TWO_DURATION, 8'h80);
      rd(ADDR_TWO_DURATION, 8'h00);
      end_test("fields");

      // or mode, magnitude against threshold 0x10
      wr(ADDR_TWO_CONFIG, 8'h3f);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h42);
      chk1(event_two_o, 1'b0);
      rd(ADDR_TWO_SOURCE, 8'h02);
      smp(16'h1000, 16'h0f00, 16'h1000, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h44);
      smp(16'h1000, 16'h1000, 16'hef00, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h60);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      wr(ADDR_TWO_CONFIG, 8'h01);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      end_test("or");

      // and mode needs both enabled axes
      wr(ADDR_TWO_CONFIG, 8'h8a);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1100, 16'h1000, 1'b1);
      end_test("and");

      // persistence of three samples, broken run restarts
      wr(ADDR_TWO_CONFIG, 8'h02);
      wr(ADDR_TWO_DURATION, 8'h03);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b1);
      wr(ADDR_TWO_DURATION, 8'h00);
      end_test("duration");

      // position mode holds while in zone
      wr(ADDR_TWO_CONFIG, 8'hff);
      smp(16'h1000, 16'h1000, 16'h1100, 1'b1);
      smp(16'h1000, 16'h1000, 16'h1100, 1'b1);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      smp(16'hef00, 16'h1000, 16'h1000, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h41);
      smp(16'h1100, 16'h1000, 16'h1100, 1'b0);
      // movement mode fires once on entry
      wr(ADDR_TWO_CONFIG, 8'h7f);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      smp(16'h1000, 16'h1000, 16'h1100, 1'b1);
      smp(16'h1000, 16'h1000, 16'h1100, 1'b0);
      end_test("orientation");

      // latched source holds until read
      @(posedge core_clk_i);
      latch_enable_i <= 1'b1;
      wr(ADDR_TWO_CONFIG, 8'h0a);
      smp(16'h1100, 16'h1000, 16'h1000, 1'b1);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b1);
      smp(16'h1000, 16'h1100, 16'h1000, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h42);
      chk1(event_two_o, 1'b0);
      smp(16'h1000, 16'h1000, 16'h1000, 1'b0);
      rd(ADDR_TWO_SOURCE, 8'h02);
      smp(16'h1000, 16'h1100, 16'h1000, 1'b1);
      rd(ADDR_TWO_SOURCE, 8'h48);
      @(posedge core_clk_i);
      latch_enable_i <= 1'b0;
      end_test("latch");

      // reboot reloads the configuration
      @(posedge core_clk_i);
      reboot_i <= 1'b1;
      @(posedge core_clk_i);
      reboot_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk1(boot_busy_o, 1'b1);
      wait_boot();
      rd(ADDR_TWO_CONFIG, 8'h00);
      end_test("reboot");
      print_verdict();
   end
endmodule
